/* hw/stpg_gate.sv */
// Per-interface spanning tree state keeper and forwarding/learning gate with an AHB-Lite slave.
`timescale 1ns/1ps
`include "stpg_params.svh"

module stpg_gate
    import stpg_pkg::*;
#(
    parameter int N_PORTS = 6,
    parameter int N_LAGS = 2,
    parameter int unsigned TICK_CYCLES = `STPG_TICK_S * `STPG_CLK_HZ
) (
    // Clock and reset.
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // AHB-Lite slave.
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // Link status from the MAC side, ports first, then groups.
    input wire logic [N_PORTS+N_LAGS-1:0] link_up_i,
    input wire logic [N_PORTS+N_LAGS-1:0][1:0] speed_i,
    input wire logic [N_LAGS-1:0] lag_fault_i,
    // Gates toward the forwarding datapath.
    output logic [N_PORTS+N_LAGS-1:0] fwd_en_o,
    output logic [N_PORTS+N_LAGS-1:0] learn_en_o,
    output logic [N_PORTS+N_LAGS-1:0] bpdu_flood_o
);

    localparam int NIF = N_PORTS + N_LAGS;

    if (N_PORTS < 1 || N_LAGS < 1 || NIF > 16 || TICK_CYCLES < 1) begin : g_bad_cfg
        $error("stpg_gate: unsupported interface count or tick length");
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // State.

    typedef struct packed {
        logic hready;
        logic pend_wr;
        logic pend_rd;
        logic [11:0] addr;
        logic [31:0] rdata;
        logic rapid;
        logic long_m;
        logic filter;
        logic [4:0] fdelay;
        logic [31:0] tick_cnt;
        logic tick;
        logic [NIF-1:0] en;
        logic [NIF-1:0] fast;
        logic [NIF-1:0] dflt;
        logic [NIF-1:0] want;
        logic [NIF-1:0][7:0] prio;
        logic [NIF-1:0][24:0] cost;
        logic [NIF-1:0][5:0] st;
        logic [NIF-1:0][4:0] secs;
        logic [NIF-1:0][31:0] trans;
        logic [NIF-1:0] fwd;
        logic [NIF-1:0] learn;
        logic [NIF-1:0] flood;
    } stpg_regs_s;

    stpg_regs_s s;
    stpg_regs_s n;
    logic [NIF-1:0] fault_v;

    // Ports never report a group fault.
    assign fault_v = {lag_fault_i, {N_PORTS{1'b0}}};

    ////////////////////////////////////////////////////////////////////////////////////////
    // Helpers.

    function automatic logic if_hit(input logic [11:0] a, input int i);
        if_hit = (a[11:4] == 8'((`STPG_OFS_IF_BASE >> `STPG_IF_SHIFT) + i));
    endfunction : if_hit

    function automatic logic [24:0] dflt_cost(input logic lag, input logic long_m,
                                              input logic [1:0] spd);
        logic [24:0] c;
        c = long_m ? `STPG_LONG_1G : `STPG_SHORT_1G;
        if (!lag) begin
            case (spd)
                STPG_SPD_10M: c = long_m ? `STPG_LONG_10M : `STPG_SHORT_10M;
                STPG_SPD_100M: c = long_m ? `STPG_LONG_100M : `STPG_SHORT_100M;
                default: c = long_m ? `STPG_LONG_1G : `STPG_SHORT_1G;
            endcase
        end
        dflt_cost = c;
    endfunction : dflt_cost

    function automatic logic [2:0] st_code(input logic [5:0] st);
        logic [2:0] c;
        case (st)
            STPG_ST_BLK: c = `STPG_CODE_BLK;
            STPG_ST_LIS: c = `STPG_CODE_LIS;
            STPG_ST_LRN: c = `STPG_CODE_LRN;
            STPG_ST_FWD: c = `STPG_CODE_FWD;
            STPG_ST_BRK: c = `STPG_CODE_BRK;
            default: c = `STPG_CODE_DIS;
        endcase
        st_code = c;
    endfunction : st_code

    ////////////////////////////////////////////////////////////////////////////////////////
    // Next state.

    always_comb begin
        logic [31:0] rd;
        logic [24:0] max_c;
        logic [5:0] base;
        logic lag;
        rd = 32'h0;
        max_c = 25'h0;
        base = STPG_ST_BLK;
        lag = 1'b0;
        n = s;

        // One-second step for the forward delay timers.
        n.tick = 1'b0;
        if (s.tick_cnt == 32'(TICK_CYCLES - 1)) begin
            n.tick_cnt = 32'h0;
            n.tick = 1'b1;
        end else begin
            n.tick_cnt = s.tick_cnt + 32'h1;
        end

        // Reads take one wait state so that a write just before is already visible.
        if (s.pend_rd && !s.hready) begin
            if (s.addr == `STPG_OFS_CTRL) begin
                rd[`STPG_CTRL_RAPID] = s.rapid;
                rd[`STPG_CTRL_LONG] = s.long_m;
                rd[`STPG_CTRL_FILTER] = s.filter;
            end else if (s.addr == `STPG_OFS_FDLY) begin
                rd[4:0] = s.fdelay;
            end
            for (int i = 0; i < NIF; i++) begin
                if (if_hit(s.addr, i)) begin
                    case (s.addr[3:2])
                        `STPG_IF_CFG: begin
                            rd[`STPG_CFG_EN] = s.en[i];
                            rd[`STPG_CFG_FAST] = s.fast[i];
                            rd[`STPG_CFG_DFLT] = s.dflt[i];
                            rd[`STPG_CFG_WANT] = s.want[i];
                            rd[`STPG_CFG_PRIO_LSB +: 8] = s.prio[i];
                        end
                        `STPG_IF_COST: begin
                            // Automatic cost while default is selected.
                            rd[24:0] = s.dflt[i] ?
                                dflt_cost(i >= N_PORTS, s.long_m, speed_i[i]) : s.cost[i];
                        end
                        `STPG_IF_STAT: begin
                            rd[2:0] = st_code(s.st[i]);
                            rd[`STPG_STAT_LINK] = link_up_i[i];
                            rd[`STPG_STAT_SPD_LSB +: 2] = speed_i[i];
                        end
                        default: rd = s.trans[i];
                    endcase
                end
            end
            n.rdata = rd;
            n.hready = 1'b1;
            n.pend_rd = 1'b0;
        end

        // Register writes land in the data phase.
        n.pend_wr = 1'b0;
        if (s.pend_wr) begin
            if (s.addr == `STPG_OFS_CTRL) begin
                n.rapid = hwdata_i[`STPG_CTRL_RAPID];
                n.long_m = hwdata_i[`STPG_CTRL_LONG];
                n.filter = hwdata_i[`STPG_CTRL_FILTER];
            end else if (s.addr == `STPG_OFS_FDLY) begin
                if (hwdata_i[31:5] == 27'h0 && hwdata_i[4:0] >= `STPG_FDLY_MIN &&
                    hwdata_i[4:0] <= `STPG_FDLY_MAX) begin
                    n.fdelay = hwdata_i[4:0];
                end
            end
            for (int i = 0; i < NIF; i++) begin
                lag = (i >= N_PORTS);
                if (if_hit(s.addr, i)) begin
                    case (s.addr[3:2])
                        `STPG_IF_CFG: begin
                            n.en[i] = hwdata_i[`STPG_CFG_EN];
                            n.fast[i] = hwdata_i[`STPG_CFG_FAST];
                            n.want[i] = hwdata_i[`STPG_CFG_WANT];
                            // Only multiples of 16 up to 240.
                            if (hwdata_i[`STPG_CFG_PRIO_LSB +: 4] == 4'h0) begin
                                n.prio[i] = hwdata_i[`STPG_CFG_PRIO_LSB +: 8];
                            end
                            if (hwdata_i[`STPG_CFG_DFLT]) begin
                                n.dflt[i] = 1'b1;
                                n.cost[i] = dflt_cost(lag, s.long_m, speed_i[i]);
                            end
                        end
                        `STPG_IF_COST: begin
                            // Range check on the path cost.
                            // Short method limits costs to 65535.
                            max_c = s.long_m ? `STPG_COST_MAX_LONG : `STPG_COST_MAX_SHORT;
                            if (hwdata_i != 32'h0 && hwdata_i <= {7'h0, max_c}) begin
                                n.cost[i] = hwdata_i[24:0];
                                n.dflt[i] = 1'b0;
                            end
                        end
                        default: begin
                        end
                    endcase
                end
            end
        end

        // Address phase capture.
        if (hsel_i && htrans_i[1] && hready_i) begin
            n.addr = {haddr_i[11:2], 2'h0};
            n.pend_wr = hwrite_i;
            n.pend_rd = !hwrite_i;
            n.hready = hwrite_i;
        end

        // Per-interface state machines.
        for (int i = 0; i < NIF; i++) begin
            // Rapid mode waits in listening, never in blocking.
            base = s.rapid ? STPG_ST_LIS : STPG_ST_BLK;
            if (!link_up_i[i]) begin
                n.st[i] = STPG_ST_DIS;
                n.secs[i] = 5'h0;
            end else if (fault_v[i]) begin
                n.st[i] = STPG_ST_BRK;
                n.secs[i] = 5'h0;
            end else if (!s.en[i]) begin
                n.st[i] = STPG_ST_FWD;
                n.secs[i] = 5'h0;
            end else begin
                case (s.st[i])
                    STPG_ST_DIS, STPG_ST_BRK: begin
                        // Fast link enters forwarding on link up.
                        n.st[i] = s.fast[i] ? STPG_ST_FWD : base;
                        n.secs[i] = 5'h0;
                    end
                    STPG_ST_BLK: begin
                        n.secs[i] = 5'h0;
                        if (s.fast[i]) begin
                            n.st[i] = STPG_ST_FWD;
                            n.trans[i] = s.trans[i] + 32'h1;
                        end else if (s.want[i] || s.rapid) begin
                            n.st[i] = STPG_ST_LIS;
                        end
                    end
                    STPG_ST_LIS, STPG_ST_LRN: begin
                        if (s.fast[i]) begin
                            n.st[i] = STPG_ST_FWD;
                            n.trans[i] = s.trans[i] + 32'h1;
                        end else if (!s.want[i]) begin
                            n.st[i] = base;
                            n.secs[i] = 5'h0;
                        end else if (s.tick) begin
                            // Each of the two states lasts the forward delay.
                            if (s.secs[i] + 5'h1 >= s.fdelay) begin
                                n.secs[i] = 5'h0;
                                if (s.st[i] == STPG_ST_LIS) begin
                                    n.st[i] = STPG_ST_LRN;
                                end else begin
                                    n.st[i] = STPG_ST_FWD;
                                    n.trans[i] = s.trans[i] + 32'h1;
                                end
                            end else begin
                                n.secs[i] = s.secs[i] + 5'h1;
                            end
                        end
                    end
                    STPG_ST_FWD: begin
                        if (!s.want[i] && !s.fast[i]) begin
                            n.st[i] = base;
                        end
                        n.secs[i] = 5'h0;
                    end
                    default: begin
                        n.st[i] = STPG_ST_DIS;
                        n.secs[i] = 5'h0;
                    end
                endcase
            end

            // Gates follow the new state so they change in the same edge as the state.
            if (!n.en[i]) begin
                // No gating when spanning tree is off here.
                n.fwd[i] = link_up_i[i];
                n.learn[i] = link_up_i[i];
            end else begin
                n.fwd[i] = (n.st[i] == STPG_ST_FWD);
                n.learn[i] = (n.st[i] == STPG_ST_FWD) || (n.st[i] == STPG_ST_LRN);
            end
            n.flood[i] = !n.en[i] && !n.filter;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Registers.

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s <= '0;
            s.hready <= 1'b1;
            s.fdelay <= `STPG_FDLY_RST;
            s.en <= {NIF{`STPG_EN_RST}};
            s.dflt <= {NIF{1'b1}};
            s.prio <= {NIF{`STPG_PRIO_RST}};
            s.cost <= {NIF{`STPG_COST_RST}};
            s.st <= {NIF{STPG_ST_DIS}};
        end else begin
            s <= n;
        end
    end

    assign hrdata_o = s.rdata;
    assign hreadyout_o = s.hready;
    // Every access completes, so the response stays OKAY.
    assign hresp_o = 1'b0;
    assign fwd_en_o = s.fwd;
    assign learn_en_o = s.learn;
    assign bpdu_flood_o = s.flood;

endmodule : stpg_gate

/* hw/stpg_params.svh */
// Offsets, field positions, reset values and timing figures of the spanning tree state gate.
`ifndef STPG_PARAMS_SVH
`define STPG_PARAMS_SVH

// Clock rate in Hz and the length of one timer step in seconds.
`define STPG_CLK_HZ 25000000
`define STPG_TICK_S 1

// Forward delay in seconds: reset value and accepted range.
`define STPG_FDLY_RST 5'h0f
`define STPG_FDLY_MIN 5'h04
`define STPG_FDLY_MAX 5'h1e

// Byte offsets of the global registers and of the interface blocks.
`define STPG_OFS_CTRL 12'h000
`define STPG_OFS_FDLY 12'h004
`define STPG_OFS_IF_BASE 12'h100
`define STPG_IF_SHIFT 4

// Word index of each register inside one interface block.
`define STPG_IF_CFG 2'h0
`define STPG_IF_COST 2'h1
`define STPG_IF_STAT 2'h2
`define STPG_IF_TRANS 2'h3

// Global control fields.
`define STPG_CTRL_RAPID 0
`define STPG_CTRL_LONG 1
`define STPG_CTRL_FILTER 2

// Interface configuration fields.
`define STPG_CFG_EN 0
`define STPG_CFG_FAST 1
`define STPG_CFG_DFLT 2
`define STPG_CFG_WANT 3
`define STPG_CFG_PRIO_LSB 8

// Interface status fields.
`define STPG_STAT_LINK 3
`define STPG_STAT_SPD_LSB 4

// Reset values of the interface settings.
`define STPG_EN_RST 1'b1
`define STPG_PRIO_RST 8'h80
`define STPG_COST_RST 25'h0000004

// Path cost limits: 65535 short, 20000000 long.
`define STPG_COST_MAX_SHORT 25'h000ffff
`define STPG_COST_MAX_LONG 25'h1312d00

// Default costs, long method: 2000000, 200000, 20000.
`define STPG_LONG_10M 25'h01e8480
`define STPG_LONG_100M 25'h0030d40
`define STPG_LONG_1G 25'h0004e20

// Default costs, short method: 100, 19, 4.
`define STPG_SHORT_10M 25'h0000064
`define STPG_SHORT_100M 25'h0000013
`define STPG_SHORT_1G 25'h0000004

// Three-bit state codes seen by software.
`define STPG_CODE_DIS 3'h0
`define STPG_CODE_BLK 3'h1
`define STPG_CODE_LIS 3'h2
`define STPG_CODE_LRN 3'h3
`define STPG_CODE_FWD 3'h4
`define STPG_CODE_BRK 3'h5

`endif

/* hw/stpg_pkg.sv */
// Types shared by the spanning tree state gate.
package stpg_pkg;

    typedef enum logic [5:0] {
        STPG_ST_DIS = 6'h01,
        STPG_ST_BLK = 6'h02,
        STPG_ST_LIS = 6'h04,
        STPG_ST_LRN = 6'h08,
        STPG_ST_FWD = 6'h10,
        STPG_ST_BRK = 6'h20
    } stpg_state_e;

    typedef enum logic [1:0] {
        STPG_SPD_10M = 2'h0,
        STPG_SPD_100M = 2'h1,
        STPG_SPD_1G = 2'h2
    } stpg_speed_e;

endpackage : stpg_pkg

/* test/stp_port_state_gate_tb.sv */
// Self-checking bench for the spanning tree state gate.
`timescale 1ns/1ps
module stp_port_state_gate_tb;
    logic ref_clk, rst, hsel, hwrite, hready, hresp;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, rdata;
    logic [2:0] link_set, link_up, fwd, learn, flood;
    logic [2:0][1:0] spd_set, speed;
    logic [0:0] flt_set, lag_fault;
    int err_count, n_compared, n;
    ////////////////////////////////////////////////////////////////////////////////
    stpg_gate #(.N_PORTS(2), .N_LAGS(1), .TICK_CYCLES(10)) dut (
        .ref_clk_i(ref_clk), .rst_i(rst), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready),
        .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .link_up_i(link_up),
        .speed_i(speed), .lag_fault_i(lag_fault), .fwd_en_o(fwd), .learn_en_o(learn),
        .bpdu_flood_o(flood));
    stpg_dp_model #(.NIF(3), .NL(1)) u_mac (.ref_clk_i(ref_clk), .rst_i(rst),
        .link_set_i(link_set), .spd_set_i(spd_set), .flt_set_i(flt_set), .link_up_o(link_up),
        .speed_o(speed), .lag_fault_o(lag_fault));
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] ia(input int i, input int k);
        return 32'h100 + 32'(16 * i + 4 * k);
    endfunction : ia
    task close_out;
        $display("mismatches %0d compared %0d", err_count, n_compared);
        if (err_count == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : close_out
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // Samples hready in mid-cycle, where it already holds what the next edge sees.
    task wait_rdy;
        int k;
        k = 0;
        @(negedge ref_clk);
        while (hready !== 1'b1 && k < 64) begin
            @(negedge ref_clk);
            k++;
        end
        if (k >= 64) begin
            chk("hready", 1'b0, 1'b1);
            close_out();
        end
        rdata = hrdata;
        chk("hresp", hresp, 32'h0);
        @(posedge ref_clk);
    endtask : wait_rdy
    task bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        hsize <= 3'h2;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
    endtask : bus
    task rdc(input string nm, input logic [31:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(nm, rdata, e);
    endtask : rdc
    task rds(input string nm, input int i, input logic [31:0] e);
        bus(1'b0, ia(i, 2), 32'h0);
        chk(nm, rdata & 32'h7, e);
    endtask : rds
    task idle(input int c);
        repeat (c) @(posedge ref_clk);
    endtask : idle
    task gates(input string nm, input int i, input logic [2:0] e);
        @(negedge ref_clk);
        chk(nm, {fwd[i], learn[i], flood[i]}, e);
        @(posedge ref_clk);
    endtask : gates
    // Ends in mid-cycle so that the caller sees settled gates.
    task wg(input int i, input logic f, input int lim);
        n = 0;
        @(negedge ref_clk);
        while ((f ? fwd[i] : learn[i]) !== 1'b1 && n < lim) begin
            @(negedge ref_clk);
            n++;
        end
        if (n >= lim) begin
            chk("gate wait", 1'b0, 1'b1);
            close_out();
        end
    endtask : wg
    ////////////////////////////////////////////////////////////////////////////////
    task s_reset;
        rdc("ctrl", 32'h0, 32'h0);
        rdc("fdly", 32'h4, 32'hf);
        rdc("cfg", ia(0, 0), 32'h8005);
        rds("state", 0, 32'h0);
        bus(1'b1, 32'h80, 32'h5a5a5a5a);
        rdc("unmapped", 32'h80, 32'h0);
    endtask : s_reset
    task s_cost;
        logic [31:0] t [6];
        t = '{32'h64, 32'h13, 32'h4, 32'h1e8480, 32'h30d40, 32'h4e20};
        for (int m = 0; m < 2; m++) begin
            bus(1'b1, 32'h0, 32'(m * 2));
            for (int s = 0; s < 3; s++) begin
                spd_set[0] <= 2'(s);
                spd_set[1] <= 2'(2 - s);
                spd_set[2] <= 2'(s);
                idle(3);
                rdc("port cost", ia(0, 1), t[m * 3 + s]);
                rdc("port1 cost", ia(1, 1), t[m * 3 + 2 - s]);
                rdc("lag speed cost", ia(2, 1), t[m * 3 + 2]);
            end
            rdc("lag cost", ia(2, 1), t[m * 3 + 2]);
        end
        bus(1'b1, ia(2, 1), 32'h1312d01);
        rdc("cost over", ia(2, 1), 32'h4e20);
        bus(1'b1, ia(2, 1), 32'h1312d00);
        rdc("cost max", ia(2, 1), 32'h1312d00);
        bus(1'b1, ia(2, 1), 32'h0);
        rdc("cost zero", ia(2, 1), 32'h1312d00);
        rdc("dflt off", ia(2, 0), 32'h8001);
        bus(1'b1, ia(2, 0), 32'h8005);
        rdc("dflt back", ia(2, 1), 32'h4e20);
        bus(1'b1, 32'h0, 32'h0);
        bus(1'b1, ia(2, 1), 32'h10000);
        rdc("short over", ia(2, 1), 32'h4);
        bus(1'b1, ia(2, 1), 32'hffff);
        rdc("short max", ia(2, 1), 32'hffff);
        bus(1'b1, ia(2, 0), 32'h8005);
    endtask : s_cost
    task s_prio;
        bus(1'b1, ia(1, 0), 32'hf005);
        rdc("prio max", ia(1, 0), 32'hf005);
        bus(1'b1, ia(1, 0), 32'h8805);
        rdc("prio step", ia(1, 0), 32'hf005);
        bus(1'b1, ia(1, 0), 32'h0005);
        rdc("prio zero", ia(1, 0), 32'h0005);
    endtask : s_prio
    task s_walk;
        bus(1'b1, 32'h4, 32'h1f);
        rdc("fdly range", 32'h4, 32'hf);
        bus(1'b1, 32'h4, 32'h4);
        link_set[0] <= 1'b1;
        idle(3);
        rds("blocking", 0, 32'h1);
        gates("blk gates", 0, 3'b000);
        bus(1'b1, ia(0, 0), 32'h800d);
        idle(1);
        rds("listening", 0, 32'h2);
        gates("lis gates", 0, 3'b000);
        wg(0, 1'b0, 200);
        chk("delay", n >= 20, 1'b1);
        chk("lrn gates", {fwd[0], learn[0], flood[0]}, 3'b010);
        idle(1);
        rds("learning", 0, 32'h3);
        wg(0, 1'b1, 200);
        chk("fwd gates", {fwd[0], learn[0], flood[0]}, 3'b110);
        idle(1);
        rds("forwarding", 0, 32'h4);
        rdc("transitions", ia(0, 3), 32'h1);
        link_set[0] <= 1'b0;
        idle(3);
        rds("down", 0, 32'h0);
        gates("down gates", 0, 3'b000);
    endtask : s_walk
    task s_fast;
        bus(1'b1, ia(1, 0), 32'h8007);
        link_set[1] <= 1'b1;
        wg(1, 1'b1, 10);
        chk("fast gates", {fwd[1], learn[1], flood[1]}, 3'b110);
        idle(1);
        rdc("fast count", ia(1, 3), 32'h0);
        link_set[1] <= 1'b0;
        bus(1'b1, ia(1, 0), 32'h8005);
        bus(1'b1, 32'h0, 32'h1);
        link_set[1] <= 1'b1;
        idle(3);
        rds("rapid wait", 1, 32'h2);
        bus(1'b1, ia(1, 0), 32'h8007);
        wg(1, 1'b1, 10);
        idle(1);
        rdc("rapid count", ia(1, 3), 32'h1);
        bus(1'b1, 32'h0, 32'h0);
        link_set[1] <= 1'b0;
    endtask : s_fast
    task s_lag;
        link_set[2] <= 1'b1;
        idle(3);
        rds("lag blocking", 2, 32'h1);
        bus(1'b1, ia(2, 0), 32'h8007);
        wg(2, 1'b1, 10);
        idle(1);
        rdc("lag count", ia(2, 3), 32'h1);
        flt_set <= 1'b1;
        idle(3);
        rds("broken", 2, 32'h5);
        gates("broken gates", 2, 3'b000);
        flt_set <= 1'b0;
        link_set[2] <= 1'b0;
    endtask : s_lag
    task s_off;
        bus(1'b1, ia(0, 0), 32'h8004);
        link_set[0] <= 1'b1;
        idle(3);
        gates("off gates", 0, 3'b111);
        rds("off state", 0, 32'h4);
        bus(1'b1, 32'h0, 32'h4);
        idle(2);
        gates("filter", 0, 3'b110);
    endtask : s_off
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        err_count = 0;
        n_compared = 0;
        rst = 1'b1;
        hsel = 1'b0;
        htrans = 2'h0;
        haddr = 32'h0;
        hwrite = 1'b0;
        hsize = 3'h0;
        hwdata = 32'h0;
        link_set = 3'h0;
        spd_set = 6'h0;
        flt_set = 1'b0;
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        s_reset();
        s_cost();
        s_prio();
        s_walk();
        s_fast();
        s_lag();
        s_off();
        close_out();
    end
endmodule : stp_port_state_gate_tb

/* test/stpg_dp_model.sv */
// Behavioural model of the MAC side that reports link, speed and group faults.
`timescale 1ns/1ps
module stpg_dp_model #(
    parameter int NIF = 3,
    parameter int NL = 1
) (
    // Clock and reset.
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Requests from the bench.
    input wire logic [NIF-1:0] link_set_i,
    input wire logic [NIF-1:0][1:0] spd_set_i,
    input wire logic [NL-1:0] flt_set_i,
    // Toward the gate.
    output logic [NIF-1:0] link_up_o,
    output logic [NIF-1:0][1:0] speed_o,
    output logic [NL-1:0] lag_fault_o
);
    // The MAC reports no link while the switch is held in reset.
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            link_up_o <= '0;
            speed_o <= '0;
            lag_fault_o <= '0;
        end else begin
            link_up_o <= link_set_i;
            speed_o <= spd_set_i;
            lag_fault_o <= flt_set_i;
        end
    end
endmodule : stpg_dp_model

/* test/stpg_gate_checker.sv */
// Port-level checks for the spanning tree state gate.
`timescale 1ns/1ps
module stpg_gate_checker #(
    parameter int N_PORTS = 6,
    parameter int N_LAGS = 2
) (
    // Clock, reset and bus.
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic hsel_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic hready_i,
    input wire logic [31:0] hrdata_o,
    input wire logic hreadyout_o,
    input wire logic hresp_o,
    // Link side and gates.
    input wire logic [N_PORTS+N_LAGS-1:0] link_up_i,
    input wire logic [N_LAGS-1:0] lag_fault_i,
    input wire logic [N_PORTS+N_LAGS-1:0] fwd_en_o,
    input wire logic [N_PORTS+N_LAGS-1:0] learn_en_o,
    input wire logic [N_PORTS+N_LAGS-1:0] bpdu_flood_o
);
    logic rd_take;
    logic wr_take;
    assign rd_take = hsel_i & htrans_i[1] & hready_i & ~hwrite_i;
    assign wr_take = hsel_i & htrans_i[1] & hready_i & hwrite_i;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////////////////////
    AST_GATE_NEEDS_LINK:
    assert property (((fwd_en_o | learn_en_o) & ~$past(link_up_i)) == '0)
        else $error("gate open on a link that was down");
    AST_FWD_WITH_LEARN:
    assert property ((fwd_en_o & ~learn_en_o) == '0) else $error("forwarding without learning");
    AST_BROKEN_NO_FWD:
    assert property ((fwd_en_o[N_PORTS+:N_LAGS] & $past(lag_fault_i)) == '0)
        else $error("faulty group still forwards");
    AST_FLOOD_OPEN:
    assert property ((bpdu_flood_o & ((fwd_en_o ^ $past(link_up_i)) | (fwd_en_o ^ learn_en_o)))
        == '0) else $error("flooding interface not following its link");
    AST_RD_ONE_WAIT:
    assert property (rd_take |=> !hreadyout_o ##1 hreadyout_o) else $error("read wait wrong");
    AST_WR_NO_WAIT:
    assert property (wr_take |=> hreadyout_o) else $error("write stalled");
    AST_RESP_OKAY:
    assert property (hresp_o == 1'b0) else $error("error response given");
    AST_RDATA_HOLD:
    assert property (!$rose(hreadyout_o) |-> $stable(hrdata_o)) else $error("read data moved");
endmodule : stpg_gate_checker

bind stpg_gate stpg_gate_checker #(.N_PORTS(N_PORTS), .N_LAGS(N_LAGS)) u_chk (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .hsel_i(hsel_i), .htrans_i(htrans_i),
    .hwrite_i(hwrite_i), .hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o), .link_up_i(link_up_i), .lag_fault_i(lag_fault_i),
    .fwd_en_o(fwd_en_o), .learn_en_o(learn_en_o), .bpdu_flood_o(bpdu_flood_o));
